// >>> pcgb_gate_bank.v
// Purpose: peripheral clock gating bank with two configuration registers
// Assumes: single clk_in at 40 MHz, asynchronous active-high reset
// Notes:   gated clocks are derived from clk_in; 1 in a gate bit stops it
//
// The register offsets and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "pcgb_regs.vh"

module pcgb_gate_bank
(
  input  wire                    clk_in,
  input  wire                    rst_in,
  input  wire [`PCGB_ADDR_W-1:0] addr_in,
  input  wire [15:0]             wdata_in,
  input  wire                    wr_in,
  input  wire                    rd_in,
  output reg  [15:0]             rdata_out,
  output wire                    i2c_clk_out,
  output wire                    card0_clk_out,
  output wire                    dma0_clk_out,
  output wire                    serial_clk_out,
  output wire                    spi_clk_out,
  output wire                    audio3_clk_out,
  output wire                    analog_regs_clk_out,
  output wire                    dma3_clk_out,
  output wire                    dma2_clk_out,
  output wire                    dma1_clk_out,
  output wire                    usb_clk_out,
  output wire                    adc_clk_out,
  output wire                    display_clk_out
);

  // ----------------------------------------------------------------
  // register storage
  // ----------------------------------------------------------------
  reg  [`PCGB_GATE_W-1:0] peripheral_gate_cfg_one_q;
  reg  [`PCGB_GATE_W-1:0] peripheral_gate_cfg_two_q;
  wire [`PCGB_NUM_CLK-1:0] stop_vec;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // true when the register index selects the given word;
  // shared by the write and the read port so both decode alike
  function reg_hit;
    input [`PCGB_ADDR_W-1:0] addr;
    input [`PCGB_ADDR_W-1:0] offset;
    begin
      reg_hit = (addr == offset);
    end
  endfunction

  // register writes; serial, usb permission and adc/display setting are software's job
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      peripheral_gate_cfg_one_q <= `PCGB_ONE_RST;
      peripheral_gate_cfg_two_q <= `PCGB_TWO_RST;
    end
    else if (wr_in)
    begin
      if (reg_hit(addr_in, `PCGB_OFF_CFG_ONE))
      begin
        peripheral_gate_cfg_one_q <= wdata_in[`PCGB_GATE_W-1:0];
      end
      else if (reg_hit(addr_in, `PCGB_OFF_CFG_TWO))
      begin
        peripheral_gate_cfg_two_q <= wdata_in[`PCGB_GATE_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  // read data one cycle after the strobe, zero otherwise
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rdata_out <= 16'h0000;
    end
    else if (rd_in && reg_hit(addr_in, `PCGB_OFF_CFG_ONE))
    begin
      rdata_out <= {9'h000, peripheral_gate_cfg_one_q};
    end
    else if (rd_in && reg_hit(addr_in, `PCGB_OFF_CFG_TWO))
    begin
      rdata_out <= {9'h000, peripheral_gate_cfg_two_q};
    end
    else
    begin
      rdata_out <= 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // gate mapping
  // ----------------------------------------------------------------
  assign stop_vec[0]  = peripheral_gate_cfg_one_q[`PCGB_BIT_I2C];
  assign stop_vec[1]  = peripheral_gate_cfg_one_q[`PCGB_BIT_CARD0];
  assign stop_vec[2]  = peripheral_gate_cfg_one_q[`PCGB_BIT_DMA0];
  assign stop_vec[3]  = peripheral_gate_cfg_one_q[`PCGB_BIT_SERIAL];
  assign stop_vec[4]  = peripheral_gate_cfg_one_q[`PCGB_BIT_SPI];
  assign stop_vec[5]  = peripheral_gate_cfg_one_q[`PCGB_BIT_AUDIO3];
  assign stop_vec[6]  = peripheral_gate_cfg_two_q[`PCGB_BIT_ANALOG];
  assign stop_vec[7]  = peripheral_gate_cfg_two_q[`PCGB_BIT_DMA3];
  assign stop_vec[8]  = peripheral_gate_cfg_two_q[`PCGB_BIT_DMA2];
  assign stop_vec[9]  = peripheral_gate_cfg_two_q[`PCGB_BIT_DMA1];
  assign stop_vec[10] = peripheral_gate_cfg_two_q[`PCGB_BIT_USB];
  assign stop_vec[11] = peripheral_gate_cfg_two_q[`PCGB_BIT_ADC];
  assign stop_vec[12] = peripheral_gate_cfg_two_q[`PCGB_BIT_DISPLAY];

  // bit 5 of the first register is storage only; it gates nothing,
  // so software that forgets to set it loses no clock

  // ----------------------------------------------------------------
  // one glitch-free gate per peripheral clock
  // ----------------------------------------------------------------
  // i2c controller clock
  pcgb_clk_gate u_gate_i2c
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[0]),
    .gclk_out (i2c_clk_out)
  );

  // card controller 0 clock
  pcgb_clk_gate u_gate_card0
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[1]),
    .gclk_out (card0_clk_out)
  );

  // dma controller 0 clock
  pcgb_clk_gate u_gate_dma0
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[2]),
    .gclk_out (dma0_clk_out)
  );

  // serial port clock
  pcgb_clk_gate u_gate_serial
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[3]),
    .gclk_out (serial_clk_out)
  );

  // spi controller clock
  pcgb_clk_gate u_gate_spi
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[4]),
    .gclk_out (spi_clk_out)
  );

  // audio port 3 clock
  pcgb_clk_gate u_gate_audio3
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[5]),
    .gclk_out (audio3_clk_out)
  );

  // analog control register clock
  pcgb_clk_gate u_gate_analog
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[6]),
    .gclk_out (analog_regs_clk_out)
  );

  // dma controller 3 clock
  pcgb_clk_gate u_gate_dma3
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[7]),
    .gclk_out (dma3_clk_out)
  );

  // dma controller 2 clock
  pcgb_clk_gate u_gate_dma2
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[8]),
    .gclk_out (dma2_clk_out)
  );

  // dma controller 1 clock
  pcgb_clk_gate u_gate_dma1
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[9]),
    .gclk_out (dma1_clk_out)
  );

  // usb controller clock; its pll is not touched here
  pcgb_clk_gate u_gate_usb
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[10]),
    .gclk_out (usb_clk_out)
  );

  // adc clock
  pcgb_clk_gate u_gate_adc
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[11]),
    .gclk_out (adc_clk_out)
  );

  // display controller clock
  pcgb_clk_gate u_gate_display
  (
    .clk_in   (clk_in),
    .stop_in  (stop_vec[12]),
    .gclk_out (display_clk_out)
  );

endmodule
`default_nettype wire

// >>> pcgb_regs.vh
// Purpose: constants for the peripheral clock gating bank
// Assumes: 16-bit registers reached over a plain address/strobe port
// Notes:   offsets are word indices on the local register port
// Function
// - first register bit 6 stops the i2c clock when set
// - first register bit 4 stops card controller 0 clock when set
// - first register bit 3 stops dma 0 clock when set
// - first register bit 2 stops the serial port clock when set
// - first register bit 1 stops the spi clock when set
// - first register bit 0 stops audio port 3 clock when set
// - second register bits 15..7 read zero; bits 6..0 writable gates, reset 0
// - second register gate bits stop their clock when 1; bit 6 covers analog regs
`ifndef PCGB_REGS_VH
`define PCGB_REGS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PCGB_ADDR_W        4
`define PCGB_OFF_CFG_ONE   4'h0
`define PCGB_OFF_CFG_TWO   4'h1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCGB_BIT_AUDIO3    0
`define PCGB_BIT_SPI       1
`define PCGB_BIT_SERIAL    2
`define PCGB_BIT_DMA0      3
`define PCGB_BIT_CARD0     4
`define PCGB_BIT_RSVD5     5
`define PCGB_BIT_I2C       6
`define PCGB_BIT_DISPLAY   0
`define PCGB_BIT_ADC       1
`define PCGB_BIT_USB       2
`define PCGB_BIT_DMA1      3
`define PCGB_BIT_DMA2      4
`define PCGB_BIT_DMA3      5
`define PCGB_BIT_ANALOG    6

// ----------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------
`define PCGB_ONE_RST       7'h00
`define PCGB_TWO_RST       7'h00
`define PCGB_GATE_W        7
`define PCGB_NUM_CLK       13

`endif

// >>> pcgb_clk_gate.v
// Purpose: glitch-free clock gate for one peripheral clock
// Assumes: stop request is synchronous to clk_in
// Notes:   enable is retimed on the falling edge, so it only moves while the clock is low
`timescale 1ns/1ps
`default_nettype none

module pcgb_clk_gate
(
  input  wire clk_in,
  input  wire stop_in,
  output wire gclk_out
);

  reg en_q;

  // falling-edge flop keeps enable steady through every high phase, no latch needed
  always @(negedge clk_in)
  begin
    en_q <= !stop_in;
  end

  assign gclk_out = clk_in & en_q;

endmodule
`default_nettype wire

// >>> pcgb_gate_bank_props.sv
// Purpose: port assertions for the gate bank
// Assumes: gate enables are retimed on the falling edge of clk_in
// Notes:   p1_q and p2_q hold the gate bits as the gate enables see them
`timescale 1ns/1ps
`default_nettype none
`include "pcgb_regs.vh"
module pcgb_gate_bank_props
(
  input wire logic clk_in, rst_in, wr_in, rd_in,
  input wire logic [`PCGB_ADDR_W-1:0] addr_in,
  input wire logic [15:0] wdata_in, rdata_out,
  input wire logic i2c_clk_out, card0_clk_out, dma0_clk_out, serial_clk_out,
  input wire logic spi_clk_out, audio3_clk_out, analog_regs_clk_out, dma3_clk_out,
  input wire logic dma2_clk_out, dma1_clk_out, usb_clk_out, adc_clk_out, display_clk_out
);
  logic [6:0] s1_q, s2_q, p1_q, p2_q;
  wire logic [5:0] g1 = {i2c_clk_out, card0_clk_out, dma0_clk_out, serial_clk_out,
    spi_clk_out, audio3_clk_out};
  wire logic [6:0] g2 = {analog_regs_clk_out, dma3_clk_out, dma2_clk_out, dma1_clk_out,
    usb_clk_out, adc_clk_out, display_clk_out};
  default clocking @(negedge clk_in); endclocking
  default disable iff (rst_in);
  // shadow gate bits; p*_q lag one edge, as the gate enables do
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
      {s1_q, s2_q, p1_q, p2_q} <= '0;
    else
    begin
      {p1_q, p2_q} <= {s1_q, s2_q};
      if (wr_in && addr_in == `PCGB_OFF_CFG_ONE) s1_q <= wdata_in[6:0];
      if (wr_in && addr_in == `PCGB_OFF_CFG_TWO) s2_q <= wdata_in[6:0];
    end
  a_i2c_gate: assert property (g1[5] != p1_q[6]) else $error("i2c clock");
  a_card_gate: assert property (g1[4] != p1_q[4]) else $error("card clock");
  a_dma0_gate: assert property (g1[3] != p1_q[3]) else $error("dma0 clock");
  a_serial_gate: assert property (g1[2] != p1_q[2]) else $error("uart clock");
  a_spi_gate: assert property (g1[1] != p1_q[1]) else $error("spi clock");
  a_audio_gate: assert property (g1[0] != p1_q[0]) else $error("audio clock");
  a_second_gates: assert property (g2 == ~p2_q) else $error("second bank");
  a_read_two:
    assert property (@(posedge clk_in) $past(rd_in) && $past(addr_in) == `PCGB_OFF_CFG_TWO
      |-> rdata_out == {9'h0, $past(s2_q)}) else $error("second readback");
  a_low_phase:
    assert property (@(posedge clk_in) {g1, g2} == 0) else $error("gated clock high");
  c_write_one: cover property (@(posedge clk_in) wr_in && addr_in == `PCGB_OFF_CFG_ONE);
  c_read_two: cover property (@(posedge clk_in) rd_in && addr_in == `PCGB_OFF_CFG_TWO);
  c_usb_off: cover property (!usb_clk_out && p2_q[2]);
endmodule
bind pcgb_gate_bank pcgb_gate_bank_props props (.*);
`default_nettype wire

// >>> pcgb_periph_model.sv
// Purpose: far-side peripherals noting that their clocks ticked
// Assumes: clr_in clears every note asynchronously
// Notes:   a stopped clock leaves its note at 0
`timescale 1ns/1ps
`default_nettype none
module pcgb_periph_model
(
  input  wire logic        clr_in,
  input  wire logic [12:0] clks_in,
  output var  logic [12:0] tick_out
);
  // one edge recorder per gated clock domain
  for (genvar i = 0; i < 13; i++)
  begin : g_dom
    always @(posedge clks_in[i] or posedge clr_in)
      tick_out[i] <= !clr_in;
  end
endmodule
`default_nettype wire

// >>> pcgb_tb.sv
// Purpose: random register traffic, readback and clock activity checks
// Assumes: reads are checked from a queue in the cycle after the strobe
// Notes:   the peer notes which gated clocks still tick
`timescale 1ns/1ps
`default_nettype none
`include "pcgb_regs.vh"
module testbench;
  logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, clr = 0, rd_q = 0;
  logic [3:0] addr_in = 0;
  logic [15:0] wdata_in = 0, d;
  logic [6:0] e1 = 0, e2 = 0;
  logic [15:0] expq[$];
  int err_count = 0, samples_checked = 0, seed = 59868;
  wire logic [15:0] rdata_out;
  wire logic [12:0] tick;
  wire logic i2c_clk_out, card0_clk_out, dma0_clk_out, serial_clk_out, spi_clk_out,
    audio3_clk_out, analog_regs_clk_out, dma3_clk_out, dma2_clk_out, dma1_clk_out,
    usb_clk_out, adc_clk_out, display_clk_out;
  pcgb_gate_bank dut (.*);
  pcgb_periph_model peer (.clr_in(clr), .tick_out(tick), .clks_in({i2c_clk_out,
    card0_clk_out, dma0_clk_out, serial_clk_out, spi_clk_out, audio3_clk_out,
    analog_regs_clk_out, dma3_clk_out, dma2_clk_out, dma1_clk_out, usb_clk_out,
    adc_clk_out, display_clk_out}));
  // system clock
  initial forever #12.5 clk_in = !clk_in;
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      err_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // write d, read it back, then see which clocks still tick
  task automatic access(logic [3:0] a);
    if (a == `PCGB_OFF_CFG_ONE) e1 = d[6:0];
    if (a == `PCGB_OFF_CFG_TWO) e2 = d[6:0];
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'h1;
    @(posedge clk_in) wr_in <= 1'h0;
    rd_in <= 1'h1;
    expq.push_back(a == 4'h0 ? {9'h0, e1} : a == 4'h1 ? {9'h0, e2} : 16'h0);
    @(posedge clk_in) rd_in <= 1'h0;
    clr <= 1'h1;
    @(posedge clk_in) clr <= 1'h0;
    repeat (3) @(posedge clk_in);
    chk("ticks", {3'h0, tick}, {3'h0, ~{e1[6], e1[4:0], e2}});
  endtask
  // take the oldest noted read and compare it with the bus
  always @(posedge clk_in)
  begin
    if (rd_q) chk("rdata", rdata_out, expq.pop_front());
    rd_q <= rd_in;
  end
  initial
  begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'h0;
    d = 16'hffff;
    access(4'h3); // unmapped write, all clocks run from reset
    repeat (40)
    begin
      d = 16'($random(seed));
      d[5] = 1'h1;
      access({2'h0, 2'($random(seed))}); // stop permission taken as granted
    end
    d = 16'h0003;
    access(`PCGB_OFF_CFG_TWO); // adc and display stopped
    rst_in <= 1'h1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'h0;
    {e1, e2} = 14'h0;
    access(4'h2); // second reset clears every gate
    complete_run;
  end
  // hang guard
  initial
  begin
    #50us;
    err_count++;
    complete_run;
  end
endmodule
`default_nettype wire
